// >>> hw/opt_pkg.sv
package opt_pkg;
	localparam int          OPT_NCH         = 11;
	// channel 0 sits at bit 15, channel 10 at bit 5
	localparam int          OPT_FLD_MSB     = 15;
	localparam int          OPT_FLD_LSB     = 5;
	// register indices; byte address is four times the index
	localparam logic [31:0] OPT_IDX_RUN     = 32'h008002fe;
	localparam logic [31:0] OPT_IDX_GUARD   = 32'h008002fc;
	localparam logic [31:0] OPT_IDX_PERMIT  = 32'h008002fa;
	localparam logic [31:0] OPT_IDX_CH0     = 32'h00800240;
	localparam logic [31:0] OPT_IDX_CH_END  = 32'h008002f0;
	localparam logic [3:0]  OPT_SUB_CNT     = 4'h0;
	localparam logic [3:0]  OPT_SUB_RELOAD  = 4'h2;
	localparam logic [3:0]  OPT_SUB_ADJ     = 4'h6;
	localparam logic [15:0] OPT_RST_CTRL    = 16'h0000;
	localparam logic [15:0] OPT_RST_DATA    = 16'h0000;
	localparam logic [1:0]  OPT_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  OPT_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OPT_K_NONE,
		OPT_K_RUN,
		OPT_K_GUARD,
		OPT_K_PERMIT,
		OPT_K_CNT,
		OPT_K_RELOAD,
		OPT_K_ADJ
	} opt_kind_e;

	typedef enum logic {
		OPT_ST_IDLE,
		OPT_ST_COUNT
	} opt_chan_st_e;
endpackage : opt_pkg

// >>> hw/opt_chan.sv
`timescale 1ns/1ns
module opt_chan
	import opt_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// count clock from the prescaler
	input  wire logic        count_tick,
	// run bit control
	input  wire logic        sw_wr,
	input  wire logic        sw_val,
	input  wire logic        ext_start,
	// values
	input  wire logic [15:0] reload_value,
	input  wire logic        adj_wr,
	input  wire logic [15:0] adj_value,
	// status and output
	output logic             channel_run_bit,
	output logic [15:0]      down_counter,
	output logic             pulse_out,
	output logic             underflow
);
	import opt_pkg::*;

	opt_chan_st_e st_q;
	logic         run_q;
	logic [15:0]  cnt_q;
	logic         ff_q;
	logic         uf_q;
	logic         ext_pend_q;
	logic         sw_set_q;
	logic         adj_pend_q;
	logic [15:0]  adj_q;
	logic         sw_clr;
	logic         ext_now;
	logic         sw_set_now;
	logic         load;
	logic         uf;

	assign sw_clr     = sw_wr && !sw_val;
	assign ext_now    = (ext_pend_q || ext_start) && !sw_clr;
	assign sw_set_now = sw_set_q || (sw_wr && sw_val);
	// start and underflow decisions wait for the count clock, hence up to one prescaler period of lag
	assign load = count_tick && st_q == OPT_ST_IDLE && run_q;
	assign uf   = count_tick && st_q == OPT_ST_COUNT && run_q && !adj_pend_q
		&& cnt_q == 16'h0000;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || count_tick || sw_clr)
			ext_pend_q <= 1'b0;
		else if (ext_start)
			ext_pend_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || sw_clr)
			sw_set_q <= 1'b0;
		else if (sw_wr)
			sw_set_q <= 1'b1;
		else if (count_tick)
			sw_set_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			run_q <= 1'b0;
		else if (sw_wr)
			run_q <= sw_val;
		else if (uf && !sw_set_now)
			run_q <= 1'b0;
		else if (count_tick && ext_now && !uf)
			run_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			adj_pend_q <= 1'b0;
			adj_q      <= OPT_RST_DATA;
		end
		else if (adj_wr)
		begin
			adj_pend_q <= 1'b1;
			adj_q      <= adj_value;
		end
		else if (count_tick)
			adj_pend_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_q  <= OPT_ST_IDLE;
			cnt_q <= OPT_RST_DATA;
			ff_q  <= 1'b0;
		end
		else if (count_tick)
		begin
			unique case (st_q)
				OPT_ST_IDLE:
					if (run_q)
					begin
						cnt_q <= reload_value;
						ff_q  <= !ff_q;
						st_q  <= OPT_ST_COUNT;
					end
				OPT_ST_COUNT:
					if (!run_q)
						st_q <= OPT_ST_IDLE;
					else if (adj_pend_q)
						// wrap past ffff is not flagged and later underflows falsely
						cnt_q <= cnt_q + adj_q;
					else
					begin
						cnt_q <= cnt_q - 16'h0001;
						if (cnt_q == 16'h0000)
						begin
							ff_q <= !ff_q;
							st_q <= OPT_ST_IDLE;
						end
					end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			uf_q <= 1'b0;
		else
			uf_q <= uf;
	end

	assign channel_run_bit = run_q;
	assign down_counter    = cnt_q;
	assign pulse_out       = ff_q;
	assign underflow       = uf_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_load;
		count_tick && st_q == OPT_ST_IDLE && run_q;
	endsequence

	sequence s_halt;
		uf && !sw_set_now && !sw_wr;
	endsequence

	a_uf_clears_run:
	assert property (s_halt |=> !run_q && st_q == OPT_ST_IDLE)
	else $error("run bit not cleared on underflow");

	a_load_reload:
	assert property (s_load |=> cnt_q == $past(reload_value) && st_q == OPT_ST_COUNT)
	else $error("start did not load reload value");

	a_pulse_toggle:
	assert property ($changed(ff_q) |-> $past(load || uf))
	else $error("output toggled without start or underflow");

	a_adj_add:
	assert property (count_tick && st_q == OPT_ST_COUNT && run_q && adj_pend_q
		|=> cnt_q == $past(cnt_q) + $past(adj_q))
	else $error("correction not added in place of decrement");

	a_ext_loses:
	assert property (s_halt and ext_now |=> !run_q ##1 !run_q || sw_wr)
	else $error("external start beat underflow halt");

	a_sw_set_wins:
	assert property (sw_wr && sw_val |=> run_q)
	else $error("software start lost");

	a_sw_clr_wins:
	assert property (sw_clr && !ext_pend_q |=> !run_q)
	else $error("software halt lost to external start");

	a_uf_wrap:
	assert property (uf |=> cnt_q == 16'hffff && uf_q ##1 !uf_q)
	else $error("underflow wrap or event pulse wrong");
endmodule : opt_chan

// >>> hw/opt_timer.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
module opt_timer
	import opt_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// axi4-lite write address
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         awaddr,
	input  wire logic [2:0]          awprot,
	// axi4-lite write data
	input  wire logic                wvalid,
	output logic                     wready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	// axi4-lite write response
	output logic                     bvalid,
	input  wire logic                bready,
	output logic [1:0]               bresp,
	// axi4-lite read address
	input  wire logic                arvalid,
	output logic                     arready,
	input  wire logic [31:0]         araddr,
	input  wire logic [2:0]          arprot,
	// axi4-lite read data
	output logic                     rvalid,
	input  wire logic                rready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	// timer side
	input  wire logic                count_tick,
	input  wire logic [OPT_NCH-1:0]  ext_start,
	output logic [OPT_NCH-1:0]       timer_out,
	output logic [OPT_NCH-1:0]       underflow_irq
);
	import opt_pkg::*;

	function automatic opt_kind_e reg_kind(input logic [31:0] a);
		logic [31:0] i;
		logic [31:0] off;
		i        = {2'b00, a[31:2]};
		off      = i - OPT_IDX_CH0;
		reg_kind = OPT_K_NONE;
		if (i == OPT_IDX_RUN)
			reg_kind = OPT_K_RUN;
		else if (i == OPT_IDX_GUARD)
			reg_kind = OPT_K_GUARD;
		else if (i == OPT_IDX_PERMIT)
			reg_kind = OPT_K_PERMIT;
		else if (i >= OPT_IDX_CH0 && i < OPT_IDX_CH_END)
		begin
			if (off[3:0] == OPT_SUB_CNT)
				reg_kind = OPT_K_CNT;
			else if (off[3:0] == OPT_SUB_RELOAD)
				reg_kind = OPT_K_RELOAD;
			else if (off[3:0] == OPT_SUB_ADJ)
				reg_kind = OPT_K_ADJ;
		end
	endfunction : reg_kind

	function automatic logic [3:0] chan_of(input logic [31:0] a);
		logic [31:0] off;
		off     = {2'b00, a[31:2]} - OPT_IDX_CH0;
		chan_of = off[7:4];
	endfunction : chan_of

	// channel c lives at bit 15-c
	function automatic logic [15:0] pack16(input logic [OPT_NCH-1:0] v);
		pack16 = 16'h0000;
		for (int c = 0; c < OPT_NCH; c++)
			pack16[OPT_FLD_MSB-c] = v[c];
	endfunction : pack16

	function automatic logic [OPT_NCH-1:0] unpack16(input logic [15:0] d);
		unpack16 = '0;
		for (int c = 0; c < OPT_NCH; c++)
			unpack16[c] = d[OPT_FLD_MSB-c];
	endfunction : unpack16

	logic                 aw_hold_q;
	logic [31:0]          aw_addr_q;
	logic                 w_hold_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;
	logic                 bvalid_q;
	logic [1:0]           bresp_q;
	logic                 rvalid_q;
	logic [31:0]          rdata_q;
	logic [1:0]           rresp_q;
	logic [OPT_NCH-1:0]   guard_q;
	logic [OPT_NCH-1:0]   permit_q;
	logic [15:0]          reload_q [OPT_NCH];
	logic [15:0]          adj_q    [OPT_NCH];
	logic [15:0]          cnt_vec  [OPT_NCH];
	logic [OPT_NCH-1:0]   run_vec;
	logic [OPT_NCH-1:0]   sw_wr;
	logic [OPT_NCH-1:0]   sw_val;
	logic [OPT_NCH-1:0]   adj_wr;
	logic [OPT_NCH-1:0]   ext_g;
	logic                 wr_fire;
	logic                 ar_fire;
	logic                 full16;
	opt_kind_e            wr_kind;
	opt_kind_e            rd_kind;
	logic [3:0]           wr_ch;
	logic [3:0]           rd_ch;
	logic [15:0]          rd_mux;

	// bus handshake
	assign awready = !aw_hold_q;
	assign wready  = !w_hold_q;
	assign arready = !rvalid_q;
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign ar_fire = arvalid && arready;
	assign wr_kind = reg_kind(aw_addr_q);
	assign wr_ch   = chan_of(aw_addr_q);
	assign rd_kind = reg_kind(araddr);
	assign rd_ch   = chan_of(araddr);
	// narrower strobes are dropped rather than merged into half a field
	assign full16  = w_strb_q[1:0] == 2'h3;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 32'h00000000;
		end
		else if (awvalid && awready)
		begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= awaddr;
		end
		else if (wr_fire)
			aw_hold_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			w_hold_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else if (wvalid && wready)
		begin
			w_hold_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
		else if (wr_fire)
			w_hold_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= OPT_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_kind == OPT_K_NONE) ? OPT_RESP_SLVERR : OPT_RESP_OKAY;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	// control registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			guard_q  <= unpack16(OPT_RST_CTRL);
			permit_q <= unpack16(OPT_RST_CTRL);
		end
		else if (wr_fire && full16)
		begin
			if (wr_kind == OPT_K_GUARD)
				guard_q <= unpack16(w_data_q[15:0]);
			if (wr_kind == OPT_K_PERMIT)
				permit_q <= unpack16(w_data_q[15:0]);
		end
	end

	// reload and correction values; neither touches a counter here
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < OPT_NCH; c++)
			begin
				reload_q[c] <= OPT_RST_DATA;
				adj_q[c]    <= OPT_RST_DATA;
			end
		end
		else if (wr_fire && full16)
		begin
			if (wr_kind == OPT_K_RELOAD)
				reload_q[wr_ch] <= w_data_q[15:0];
			if (wr_kind == OPT_K_ADJ)
				adj_q[wr_ch] <= w_data_q[15:0];
		end
	end

	// run bit writes pass only where the guard is open
	assign sw_wr  = (wr_fire && full16 && wr_kind == OPT_K_RUN) ? ~guard_q : '0;
	assign sw_val = unpack16(w_data_q[15:0]);
	assign ext_g  = ext_start & permit_q;

	always_comb
	begin
		adj_wr = '0;
		if (wr_fire && full16 && wr_kind == OPT_K_ADJ)
			adj_wr[wr_ch] = 1'b1;
	end

	generate
		for (genvar g = 0; g < OPT_NCH; g++)
		begin : g_ch
			opt_chan u_chan (
				.core_clk        (core_clk),
				.rst_n           (rst_n),
				.count_tick      (count_tick),
				.sw_wr           (sw_wr[g]),
				.sw_val          (sw_val[g]),
				.ext_start       (ext_g[g]),
				.reload_value    (reload_q[g]),
				.adj_wr          (adj_wr[g]),
				.adj_value       (w_data_q[15:0]),
				.channel_run_bit (run_vec[g]),
				.down_counter    (cnt_vec[g]),
				.pulse_out       (timer_out[g]),
				.underflow       (underflow_irq[g])
			);
		end
	endgenerate

	// read side
	always_comb
	begin
		rd_mux = 16'h0000;
		unique case (rd_kind)
			OPT_K_NONE:   rd_mux = 16'h0000;
			OPT_K_RUN:    rd_mux = pack16(run_vec);
			OPT_K_GUARD:  rd_mux = pack16(guard_q);
			OPT_K_PERMIT: rd_mux = pack16(permit_q);
			OPT_K_CNT:    rd_mux = cnt_vec[rd_ch];
			OPT_K_RELOAD: rd_mux = reload_q[rd_ch];
			OPT_K_ADJ:    rd_mux = adj_q[rd_ch];
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= OPT_RESP_OKAY;
		end
		else if (ar_fire)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= {16'h0000, rd_mux};
			rresp_q  <= (rd_kind == OPT_K_NONE) ? OPT_RESP_SLVERR : OPT_RESP_OKAY;
		end
		else if (rready)
			rvalid_q <= 1'b0;
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_guard_gate:
	assert property (wr_fire && wr_kind == OPT_K_RUN && guard_q[0]
		|=> run_vec[0] == $past(run_vec[0]) || $past(count_tick))
	else $error("guarded run bit was rewritten");

	a_run_readback:
	assert property (ar_fire && rd_kind == OPT_K_RUN
		|=> rvalid && rdata[15:0] == $past(pack16(run_vec)) && rdata[4:0] == 5'h00)
	else $error("run readback differs from channel state");

	a_bresp_hold:
	assert property (bvalid && !bready |=> bvalid && $stable(bresp))
	else $error("write response dropped before taken");

	a_write_answer:
	assert property (wr_fire |=> bvalid ##0 !aw_hold_q && !w_hold_q)
	else $error("write not answered one cycle after both halves");
endmodule : opt_timer

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import opt_pkg::*;

	logic               core_clk;
	logic               rst_n;
	logic               count_tick;
	logic               awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready;
	logic [31:0]        awaddr, wdata, araddr, rdata, rd, seed;
	logic [3:0]         wstrb;
	logic [2:0]         tdiv;
	logic [1:0]         bresp, rresp, rsp;
	logic [OPT_NCH-1:0] ext_start, timer_out, underflow_irq, prev_out;
	int                 fails, num_checks, c, r, n;
	int                 hi_n[OPT_NCH], w_last[OPT_NCH], irq_n[OPT_NCH];

	opt_timer i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.count_tick(count_tick), .ext_start(ext_start),
		.timer_out(timer_out), .underflow_irq(underflow_irq));

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// one count tick every eight core cycles
	always @(posedge core_clk)
	begin
		tdiv <= tdiv + 3'h1;
		count_tick <= (tdiv == 3'h7);
	end

	// sampled mid-cycle, so values match what the next rising edge sees
	always @(negedge core_clk)
		for (int i = 0; i < OPT_NCH; i++)
		begin
			if (count_tick === 1'b1 && timer_out[i] === 1'b1)
				hi_n[i]++;
			if (prev_out[i] === 1'b1 && timer_out[i] === 1'b0)
			begin
				w_last[i] = hi_n[i];
				hi_n[i] = 0;
			end
			if (underflow_irq[i] === 1'b1)
				irq_n[i]++;
			prev_out[i] = timer_out[i];
		end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [31:0] ch_idx(input int ch, input logic [3:0] sub);
		return OPT_IDX_CH0 + 32'(ch) * 32'h10 + {28'h0, sub};
	endfunction : ch_idx

	function automatic logic [15:0] ch_bit(input int ch);
		return 16'h0001 << (OPT_FLD_MSB - ch);
	endfunction : ch_bit

	// pulse width in ticks; a correction adds its value plus one
	function automatic int exp_w(input int rl, input int adj);
		return rl + 1 + ((adj == 0) ? 0 : adj + 1);
	endfunction : exp_w

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic hang();
		fails++;
		test_done();
	endtask : hang

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask : chk

	task automatic axi_wr(input logic [31:0] idx, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] br;
		awaddr <= {idx[29:0], 2'b00};
		wdata <= {16'h0000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (int k = 0; k < 40 && !tb; k++)
		begin
			@(negedge core_clk);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			tb = bvalid === 1'b1;
			br = bresp;
			@(posedge core_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		// let an edge pass so a following call never reassigns bready in this step
		@(posedge core_clk);
		if (!tb)
			hang();
		chk("bresp", {30'h0, br}, {30'h0, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] idx);
		logic ta, got;
		araddr <= {idx[29:0], 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		got = 1'b0;
		for (int k = 0; k < 40 && !got; k++)
		begin
			@(negedge core_clk);
			ta = arvalid && arready === 1'b1;
			got = rvalid === 1'b1;
			rd = rdata;
			rsp = rresp;
			@(posedge core_clk);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge core_clk);
		if (!got)
			hang();
	endtask : axi_rd

	task automatic rd_chk(input string nm, input logic [31:0] idx, input logic [15:0] exp);
		axi_rd(idx);
		chk(nm, {rd[31:0], 30'h0, rsp}, {16'h0000, exp, 30'h0, OPT_RESP_OKAY});
	endtask : rd_chk

	task automatic wait_pulse(input int ch, input int ew);
		for (int k = 0; k < ew * 8 + 80 && w_last[ch] < 0; k++)
			@(posedge core_clk);
		if (w_last[ch] < 0)
			hang();
		chk("pulse width", 32'(w_last[ch]), 32'(ew));
	endtask : wait_pulse

	task automatic ext_pulse(input int ch, input int len);
		ext_start[ch] <= 1'b1;
		repeat (len) @(posedge core_clk);
		ext_start[ch] <= 1'b0;
	endtask : ext_pulse

	task automatic sw_shot(input int ch, input int rl);
		w_last[ch] = -1;
		irq_n[ch] = 0;
		axi_wr(ch_idx(ch, OPT_SUB_RELOAD), 16'(rl), 4'h3, OPT_RESP_OKAY);
		axi_wr(OPT_IDX_RUN, ch_bit(ch), 4'h3, OPT_RESP_OKAY);
		rd_chk("run set", OPT_IDX_RUN, ch_bit(ch));
		wait_pulse(ch, rl + 1);
		repeat (3) @(posedge core_clk);
		chk("irq count", 32'(irq_n[ch]), 32'h1);
		rd_chk("run cleared", OPT_IDX_RUN, 16'h0000);
		rd_chk("counter wrap", ch_idx(ch, OPT_SUB_CNT), 16'hffff);
	endtask : sw_shot

	initial
	begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, count_tick} = '0;
		{awaddr, wdata, araddr, wstrb, tdiv, ext_start, prev_out} = '0;
		fails = 0;
		num_checks = 0;
		seed = 32'd97139;
		for (int i = 0; i < OPT_NCH; i++)
		begin
			hi_n[i] = 0;
			irq_n[i] = 0;
			w_last[i] = -1;
		end
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd_chk("run reset", OPT_IDX_RUN, OPT_RST_CTRL);
		rd_chk("guard reset", OPT_IDX_GUARD, OPT_RST_CTRL);
		rd_chk("permit reset", OPT_IDX_PERMIT, OPT_RST_CTRL);
		axi_rd(32'h00800000);
		chk("unmapped", {rd, 30'h0, rsp}, {32'h0, 30'h0, OPT_RESP_SLVERR});
		$display("reset and map test done");
		// edge channels and shortest reload first, then random ones
		for (int i = 0; i < 5; i++)
		begin
			seed = lfsr_next(seed);
			c = (i < 2) ? i * 10 : int'(seed[15:0] % 16'd11);
			r = (i < 2) ? i : int'(seed[23:20]);
			sw_shot(c, r);
		end
		$display("one-shot test done");
		axi_wr(ch_idx(c, OPT_SUB_RELOAD), 16'h1234, 4'h3, OPT_RESP_OKAY);
		rd_chk("counter kept", ch_idx(c, OPT_SUB_CNT), 16'hffff);
		axi_wr(ch_idx(c, OPT_SUB_RELOAD), 16'h5678, 4'h1, OPT_RESP_OKAY);
		rd_chk("byte write", ch_idx(c, OPT_SUB_RELOAD), 16'h1234);
		axi_wr(OPT_IDX_GUARD, ch_bit(c), 4'h3, OPT_RESP_OKAY);
		rd_chk("guard set", OPT_IDX_GUARD, ch_bit(c));
		axi_wr(OPT_IDX_RUN, ch_bit(c), 4'h3, OPT_RESP_OKAY);
		rd_chk("guarded run", OPT_IDX_RUN, 16'h0000);
		axi_wr(OPT_IDX_GUARD, 16'h0000, 4'h3, OPT_RESP_OKAY);
		$display("register test done");
		axi_wr(ch_idx(c, OPT_SUB_RELOAD), 16'h0004, 4'h3, OPT_RESP_OKAY);
		ext_pulse(c, 10);
		repeat (40) @(posedge core_clk);
		chk("ext ignored", {31'h0, timer_out[c]}, 32'h0);
		axi_wr(OPT_IDX_PERMIT, ch_bit(c), 4'h3, OPT_RESP_OKAY);
		w_last[c] = -1;
		ext_pulse(c, 10);
		wait_pulse(c, 5);
		$display("external start test done");
		for (int k = 0; k < 2; k++)
		begin
			axi_wr(ch_idx(c, OPT_SUB_RELOAD), 16'h000a, 4'h3, OPT_RESP_OKAY);
			w_last[c] = -1;
			axi_wr(OPT_IDX_RUN, ch_bit(c), 4'h3, OPT_RESP_OKAY);
			repeat (24) @(posedge core_clk);
			axi_wr(ch_idx(c, OPT_SUB_ADJ), k ? 16'hfffe : 16'h0003, 4'h3, OPT_RESP_OKAY);
			wait_pulse(c, exp_w(10, k ? -2 : 3));
		end
		$display("correction test done");
		w_last[c] = -1;
		for (n = 0; n < 20 && count_tick !== 1'b1; n++)
			@(negedge core_clk);
		@(posedge core_clk);
		fork
			ext_pulse(c, 2);
			axi_wr(OPT_IDX_RUN, 16'h0000, 4'h3, OPT_RESP_OKAY);
		join
		repeat (40) @(posedge core_clk);
		chk("halt wins", {31'h0, timer_out[c]}, 32'h0);
		rd_chk("halt run", OPT_IDX_RUN, 16'h0000);
		$display("priority test done");
		test_done();
	end
endmodule : tb_top
